// ---- hw/tlrm_ch_if.sv ----
// per channel report bundle from a channel monitor to the top
`timescale 1ns/100ps
interface tlrm_ch_if;
  import tlrm_pkg::*;
  logic [NEV-1:0] ev;
  logic [FRAME_W-1:0] word;
  logic [1:0] live;
  modport mon (output ev, output word, output live);
  modport top (input ev, input word, input live);
endinterface : tlrm_ch_if

// ---- hw/tlrm_chan_mon.sv ----
// one link channel: sampling, rate check, frame decode and watchdogs
`timescale 1ns/100ps
module tlrm_chan_mon #(
  parameter int STALL_MS = tlrm_pkg::STALL_MS,
  parameter int INACT_MS = tlrm_pkg::INACT_MS,
  parameter int LC_TMO_MS = tlrm_pkg::LC_TMO_MS
) (
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // link pins and time base
  input logic clk_pin,
  input logic data_pin,
  input logic ms_tick,
  // report
  tlrm_ch_if.mon ch
);
  import tlrm_pkg::*;

  typedef struct packed {
    logic [7:0] gap;
    logic gap_ok;
    logic [10:0] sum;
    logic [2:0] ecnt;
    logic [6:0] ones;
    logic [7:0] sh;
    logic [15:0] body;
    logic [3:0] bcnt;
    logic [9:0] stall_ms;
    logic [9:0] inact_ms;
    logic [9:0] lcm_ms;
    logic stall_lv;
    logic inact_lv;
    logic [NEV-1:0] ev;
    logic [FRAME_W-1:0] word;
  } tlrm_mon_s;

  if (STALL_MS < 1 || STALL_MS > 1023 || INACT_MS < 1 || INACT_MS > 1023 || LC_TMO_MS < 1 || LC_TMO_MS > 1023)
  begin : g_bad
    $error("tlrm_chan_mon: watchdog times must be 1..1023 ms");
  end

  logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2, dat_s3;
  tlrm_mon_s r, n;
  tlrm_dec_e st, st_next;
  logic rise, clk_edge, bit_in;

  // two stage synchronisers plus one history stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {clk_s1, clk_s2, clk_s3} <= 3'h0;
      {dat_s1, dat_s2, dat_s3} <= 3'h0;
    end else begin
      {clk_s1, clk_s2, clk_s3} <= {clk_pin, clk_s1, clk_s2};
      {dat_s1, dat_s2, dat_s3} <= {data_pin, dat_s1, dat_s2};
    end
  end

  // edges are taken from the second and third stages only
  assign rise = clk_s2 & ~clk_s3;
  assign clk_edge = clk_s2 ^ clk_s3;
  assign bit_in = dat_s2;

  // next state of the channel
  always_comb begin
    logic [10:0] sum_now;
    logic [7:0] sh_now;
    logic [15:0] body_now;
    sum_now = r.sum + 11'(r.gap);
    sh_now = {r.sh[6:0], bit_in};
    body_now = {r.body[14:0], bit_in};
    n = r;
    st_next = st;
    n.ev = '0;
    // bit period measured over a window of clock rises
    if (rise) begin
      n.gap = 8'h01;
      n.gap_ok = 1'b1;
      if (r.gap_ok) begin
        n.sum = sum_now;
        n.ecnt = r.ecnt + 3'h1;
        if (r.ecnt == 3'(RATE_WIN - 1)) begin
          n.sum = 11'h000;
          n.ecnt = 3'h0;
          n.ev[EV_RATE] = (sum_now < 11'(RATE_LO)) || (sum_now > 11'(RATE_HI));
        end
      end
    end else if (r.gap == 8'hFF) begin
      n.gap_ok = 1'b0;
      n.sum = 11'h000;
      n.ecnt = 3'h0;
    end else begin
      n.gap = r.gap + 8'h01;
    end
    // bit stream: link check runs and frames
    if (rise) begin
      n.sh = sh_now;
      if (bit_in) begin
        if (r.ones != 7'h7F) n.ones = r.ones + 7'h01;
        n.ev[EV_LCLONG] = (r.ones == 7'(LC_MAX_BITS));
      end else begin
        n.ones = 7'h00;
        if (r.ones >= 7'(LC_MIN_BITS) && r.ones <= 7'(LC_MAX_BITS)) n.lcm_ms = 10'h000;
      end
      unique case (st)
        DEC_HUNT: begin
          if (sh_now == SYNC_WORD) begin
            st_next = DEC_BODY;
            n.bcnt = 4'h0;
          end
        end
        DEC_BODY: begin
          n.body = body_now;
          n.bcnt = r.bcnt + 4'h1;
          if (n.ones >= 7'(LC_GUARD_BITS)) begin
            st_next = DEC_HUNT;
          end else if (r.bcnt == 4'(FRAME_W - 1)) begin
            st_next = DEC_HUNT;
            n.word = body_now;
            n.ev[EV_PASS] = 1'b1;
            n.ev[EV_LOST] = ^body_now;
            n.ev[EV_FSK] = body_now[FSK_BIT];
          end
        end
        default: st_next = DEC_HUNT;
      endcase
    end
    // clock stall watchdog
    if (clk_edge) begin
      n.stall_ms = 10'h000;
      n.stall_lv = 1'b0;
    end else if (ms_tick && !r.stall_lv) begin
      n.stall_ms = r.stall_ms + 10'h001;
      if (r.stall_ms == 10'(STALL_MS - 1)) begin
        n.stall_lv = 1'b1;
        n.ev[EV_STALL] = 1'b1;
      end
    end
    // inactivity watchdog on both lines
    if (clk_edge || (dat_s2 ^ dat_s3)) begin
      n.inact_ms = 10'h000;
      n.inact_lv = 1'b0;
    end else if (ms_tick && !r.inact_lv) begin
      n.inact_ms = r.inact_ms + 10'h001;
      if (r.inact_ms == 10'(INACT_MS - 1)) begin
        n.inact_lv = 1'b1;
        n.ev[EV_INACT] = 1'b1;
      end
    end
    // missing link check watchdog, repeats each timeout
    if (ms_tick && n.lcm_ms == r.lcm_ms) begin
      n.lcm_ms = r.lcm_ms + 10'h001;
      if (r.lcm_ms == 10'(LC_TMO_MS - 1)) begin
        n.lcm_ms = 10'h000;
        n.ev[EV_LCMISS] = 1'b1;
      end
    end
  end

  // register the channel state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      st <= DEC_HUNT;
    end else begin
      r <= n;
      st <= st_next;
    end
  end

  assign ch.ev = r.ev;
  assign ch.word = r.word;
  assign ch.live = {r.inact_lv, r.stall_lv};

  a_rate_window: assert property (@(posedge hclk) disable iff (!hresetn)
    r.ev[EV_RATE] |-> $past(rise) && $past(r.ecnt) == 3'h7)
    else $error("rate fault outside a window end");
  a_long_run: assert property (@(posedge hclk) disable iff (!hresetn)
    (rise && bit_in && r.ones == 7'h40) |=> r.ev[EV_LCLONG])
    else $error("over-long link check not flagged");
  a_stall_once: assert property (@(posedge hclk) disable iff (!hresetn)
    r.ev[EV_STALL] |-> r.stall_lv ##1 !r.ev[EV_STALL])
    else $error("stall event not single");
  a_edge_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_edge |=> !r.stall_lv && r.stall_ms == 10'h000)
    else $error("clock edge did not clear stall");

endmodule : tlrm_chan_mon

// ---- hw/tlrm_pkg.sv ----
// constants, event layout and register map of the track link receiver monitor
package tlrm_pkg;

  // ----------------------------------------
  // clock and time base
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_NS = 8;
  localparam int MS_CYC = CLK_HZ / 1000;

  // ----------------------------------------
  // link bit timing
  // ----------------------------------------
  localparam int BIT_NS = 64;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam int RATE_WIN = 8;
  localparam int TOL_PCT = 10;
  localparam int RATE_NOM = BIT_CYC * RATE_WIN;
  // fault threshold sits at one and a quarter tolerance bands
  localparam int RATE_LO = RATE_NOM - (RATE_NOM * TOL_PCT * 5) / 400;
  localparam int RATE_HI = RATE_NOM + (RATE_NOM * TOL_PCT * 5) / 400;

  // ----------------------------------------
  // supervision times in ms
  // ----------------------------------------
  localparam int STALL_MS = 500;
  localparam int INACT_MS = 1000;
  localparam int LC_TMO_MS = 600;

  // ----------------------------------------
  // link check and frame format
  // ----------------------------------------
  localparam int LC_MIN_BITS = 24;
  localparam int LC_MAX_BITS = 64;
  localparam int LC_GUARD_BITS = 8;
  localparam logic [7:0] SYNC_WORD = 8'h5A;
  localparam int FRAME_W = 16;
  localparam int FSK_BIT = 15;

  // ----------------------------------------
  // per channel event bits
  // ----------------------------------------
  localparam int NEV = 8;
  localparam int EV_RATE = 0;
  localparam int EV_LOST = 1;
  localparam int EV_LCMISS = 2;
  localparam int EV_LCLONG = 3;
  localparam int EV_STALL = 4;
  localparam int EV_INACT = 5;
  localparam int EV_PASS = 6;
  localparam int EV_FSK = 7;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_LIVE = 8'h0C;
  localparam logic [7:0] OFF_WORD = 8'h10;
  localparam logic [7:0] OFF_PASS = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  // frame decoder states
  typedef enum logic [1:0] {
    DEC_HUNT = 2'b01,
    DEC_BODY = 2'b10
  } tlrm_dec_e;

endpackage : tlrm_pkg

// ---- hw/tlrm_top.sv ----
// top of the track link receiver monitor with its ahb-lite registers
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps

// Overview of operation
// - Decode frames unchanged at nominal, lowest and highest link bit rate.
// - Flag a rate fault when bit rate is well beyond tolerance.
// - Only clock rises matter, so any permitted pulse length works.
// - Each channel samples on its own clock, so skew is harmless.
// - Every passage is reported; bad parity raises lost telegram.
// - Type indication bit is reported without any fault.
// - Missing link checks within the timeout raise a fault.
// - A link check run beyond its maximum length raises a fault.
// - A link check inside a passage aborts the frame silently.
// - Clock constant beyond the stall time reports control unavailable.
// - No edges on clock or data reports the link inactive.
// - All checks run per channel with their own status bits.
// - Channels are redundant copies; any good one updates the word.
module tlrm_top #(
  parameter int NCH = 2,
  parameter int MS_CYC = tlrm_pkg::MS_CYC,
  parameter int STALL_MS = tlrm_pkg::STALL_MS,
  parameter int INACT_MS = tlrm_pkg::INACT_MS,
  parameter int LC_TMO_MS = tlrm_pkg::LC_TMO_MS
) (
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // ahb-lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // link pins, one pair per channel
  input logic [NCH-1:0] link_clk,
  input logic [NCH-1:0] link_data,
  // host reporting
  output logic irq,
  output logic [NCH-1:0] unavail
);
  import tlrm_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  localparam int MSW = $clog2(MS_CYC);

  if (NCH < 1 || NCH > 4) begin : g_bad_nch
    $error("tlrm_top: NCH must be 1..4");
  end
  if (MS_CYC < 2) begin : g_bad_ms
    $error("tlrm_top: MS_CYC must be at least 2");
  end

  // ----------------------------------------
  // millisecond time base
  // ----------------------------------------
  logic [MSW-1:0] ms_cnt_reg, ms_cnt_next;
  logic ms_tick_reg, ms_tick_next;

  // free running prescaler for the watchdogs
  always_comb begin
    ms_tick_next = 1'b0;
    ms_cnt_next = ms_cnt_reg + 1'b1;
    if (ms_cnt_reg == MSW'(MS_CYC - 1)) begin
      ms_cnt_next = '0;
      ms_tick_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_reg <= '0;
      ms_tick_reg <= 1'b0;
    end else begin
      ms_cnt_reg <= ms_cnt_next;
      ms_tick_reg <= ms_tick_next;
    end
  end

  // ----------------------------------------
  // channel monitors
  // ----------------------------------------
  logic [31:0] ev_flat;
  logic [NCH-1:0] good_pass;
  logic [NCH-1:0] any_pass;
  logic [NCH*FRAME_W-1:0] words;
  logic [NCH-1:0] stall_lv;
  logic [NCH-1:0] inact_lv;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    tlrm_ch_if u_if ();

    // each channel is checked on its own, skew between them is free
    tlrm_chan_mon #(
      .STALL_MS(STALL_MS),
      .INACT_MS(INACT_MS),
      .LC_TMO_MS(LC_TMO_MS)
    ) u_mon (
      .hclk(hclk),
      .hresetn(hresetn),
      .clk_pin(link_clk[i]),
      .data_pin(link_data[i]),
      .ms_tick(ms_tick_reg),
      .ch(u_if.mon)
    );

    // gather reports, one event byte per channel
    assign ev_flat[i*NEV +: NEV] = u_if.ev;
    assign good_pass[i] = u_if.ev[EV_PASS] & ~u_if.ev[EV_LOST];
    assign any_pass[i] = u_if.ev[EV_PASS];
    assign words[i*FRAME_W +: FRAME_W] = u_if.word;
    assign stall_lv[i] = u_if.live[0];
    assign inact_lv[i] = u_if.live[1];
  end

  if (NCH < 4) begin : g_pad
    assign ev_flat[31:NCH*NEV] = '0;
  end

  // ----------------------------------------
  // register file and bus slave
  // ----------------------------------------
  logic [31:0] status_reg, status_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [FRAME_W-1:0] word_reg, word_next;
  logic [31:0] pass_reg, pass_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] waddr_reg, waddr_next;
  logic wpend_reg, wpend_next;
  logic irq_reg, irq_next;
  logic [NCH-1:0] unav_reg, unav_next;
  logic [31:0] ev_set;
  logic [31:0] w1c;
  logic [31:0] live_word;
  logic take;

  assign take = hsel && htrans[1] && hready;
  assign ev_set = ctrl_reg[CTRL_EN_BIT] ? ev_flat : 32'h0000_0000;

  // live levels: stall in low half, inactive in high half
  always_comb begin
    live_word = 32'h0000_0000;
    live_word[NCH-1:0] = stall_lv;
    live_word[16 +: NCH] = inact_lv;
  end

  // next values of the registers and the bus answer
  always_comb begin
    status_next = status_reg;
    mask_next = mask_reg;
    ctrl_next = ctrl_reg;
    word_next = word_reg;
    pass_next = pass_reg;
    rdata_next = rdata_reg;
    waddr_next = waddr_reg;
    wpend_next = 1'b0;
    w1c = 32'h0000_0000;
    // data phase of a write
    if (wpend_reg) begin
      unique case (waddr_reg)
        OFF_STATUS: w1c = hwdata;
        OFF_MASK: mask_next = hwdata;
        OFF_CTRL: ctrl_next = hwdata & CTRL_RST;
        default: ;
      endcase
    end
    // sticky events, a new event wins over the clear
    status_next = (status_reg & ~w1c) | ev_set;
    // every good copy of any channel updates the word, the lowest channel wins in one cycle
    for (int k = NCH - 1; k >= 0; k--) begin
      if (good_pass[k] && ctrl_reg[CTRL_EN_BIT]) word_next = words[k*FRAME_W +: FRAME_W];
    end
    if (|any_pass && ctrl_reg[CTRL_EN_BIT]) pass_next = pass_reg + 32'h0000_0001;
    // address phase
    if (take) begin
      waddr_next = haddr[7:0];
      wpend_next = hwrite;
      if (!hwrite) begin
        unique case (haddr[7:0])
          OFF_STATUS: rdata_next = status_reg;
          OFF_MASK: rdata_next = mask_reg;
          OFF_CTRL: rdata_next = ctrl_reg;
          OFF_LIVE: rdata_next = live_word;
          OFF_WORD: rdata_next = {16'h0000, word_reg};
          OFF_PASS: rdata_next = pass_reg;
          default: rdata_next = 32'h0000_0000;
        endcase
      end
    end
    irq_next = |(status_next & mask_next);
    unav_next = stall_lv | inact_lv;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= 32'h0000_0000;
      mask_reg <= MASK_RST;
      ctrl_reg <= CTRL_RST;
      word_reg <= '0;
      pass_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
      waddr_reg <= 8'h00;
      wpend_reg <= 1'b0;
      irq_reg <= 1'b0;
      unav_reg <= '0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      ctrl_reg <= ctrl_next;
      word_reg <= word_next;
      pass_reg <= pass_next;
      rdata_reg <= rdata_next;
      waddr_reg <= waddr_next;
      wpend_reg <= wpend_next;
      irq_reg <= irq_next;
      unav_reg <= unav_next;
    end
  end

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign irq = irq_reg;
  assign unavail = unav_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_status_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (|ev_set) |=> ((status_reg & $past(ev_set)) == $past(ev_set)))
    else $error("event did not latch in status");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(status_reg & mask_reg))
    else $error("interrupt level mismatch");
  a_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ctrl_reg[CTRL_EN_BIT] && !wpend_reg) |=> status_reg == $past(status_reg))
    else $error("status changed while disabled");
  a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && haddr[7:0] > OFF_PASS) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_unavail_stall: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(stall_lv[0]) |=> unavail[0])
    else $error("stall not reported as unavailable");
  a_tick_period: assert property (@(posedge hclk) disable iff (!hresetn)
    ms_tick_reg |=> !ms_tick_reg)
    else $error("time base tick too long");

endmodule : tlrm_top

// ---- sim/testbench.sv ----
// self-checking testbench of the track link receiver monitor
`timescale 1ns/100ps
module testbench;
  import tlrm_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hready;
  wire [31:0] hrdata;
  wire hresp;
  wire irq;
  wire [1:0] unavail;
  wire [1:0] link_clk;
  wire [1:0] link_data;
  int fail_count = 0;
  int n_tests = 0;

  // ----------------------------------------
  // design and link transmitters
  // ----------------------------------------
  tlrm_top #(.NCH(2), .MS_CYC(20), .STALL_MS(50), .INACT_MS(100), .LC_TMO_MS(80)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .link_clk(link_clk), .link_data(link_data),
    .irq(irq), .unavail(unavail)
  );
  tlrm_link_src u_src0 (.clk_o(link_clk[0]), .data_o(link_data[0]));
  tlrm_link_src u_src1 (.clk_o(link_clk[1]), .data_o(link_data[1]));

  // system clock, 8 ns period
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ----------------------------------------
  // bus, compare and report helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hsize <= 3'h2;
    hwrite <= 1'b1;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hsize <= 3'h2;
    hwrite <= 1'b0;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d & m, exp);
  endtask : rdchk

  task automatic setp(input int p0, input int p1);
    u_src0.per_ns = p0;
    u_src0.hi_ns = p0 / 2;
    u_src1.per_ns = p1;
    u_src1.hi_ns = p1 / 2;
  endtask : setp

  // link check then frame on both channels, each after its own delay
  // link clocks rest over 255 cycles so the rate window starts afresh
  task automatic rest();
    repeat (300) @(posedge hclk);
  endtask : rest

  task automatic pair(input logic [15:0] w0, input logic [15:0] w1, input int d0, input int d1);
    rest();
    fork
      begin
        #(d0);
        u_src0.lc(32);
        u_src0.frame(w0, 24);
        u_src0.idle();
      end
      begin
        #(d1);
        u_src1.lc(32);
        u_src1.frame(w1, 24);
        u_src1.idle();
      end
    join
    repeat (8) @(posedge hclk);
  endtask : pair

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdchk(OFF_CTRL, 32'hFFFFFFFF, CTRL_RST);
    rdchk(OFF_MASK, 32'hFFFFFFFF, MASK_RST);
    rdchk(OFF_STATUS, 32'hFFFFFFFF, 32'h00000000);
    wr(OFF_CTRL, 32'hFFFFFFFF);
    rdchk(OFF_CTRL, 32'hFFFFFFFF, 32'h00000001);
    rdchk(8'h20, 32'hFFFFFFFF, 32'h00000000);
    check({31'h0, hresp}, 32'h00000000);
    $display("registers done");
  endtask : t_regs

  task automatic t_good(input int p, input int h, input int d0, input int d1);
    wr(OFF_STATUS, 32'hFFFFFFFF);
    setp(p, p);
    u_src0.hi_ns = h;
    u_src1.hi_ns = h;
    pair(16'h1233, 16'h1233, d0, d1);
    rdchk(OFF_STATUS, 32'hFFFFFFFF, 32'h00004040);
    rdchk(OFF_WORD, 32'h0000FFFF, 32'h00001233);
    $display("good traffic period %0d high %0d done", p, h);
  endtask : t_good

  task automatic t_lost();
    setp(64, 64);
    wr(OFF_STATUS, 32'hFFFFFFFF);
    pair(16'h1234, 16'h1233, 0, 0);
    rdchk(OFF_STATUS, 32'hFFFFFFFF, 32'h00004042);
    wr(OFF_MASK, 32'h00000002);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h00000001);
    wr(OFF_STATUS, 32'hFFFFFFFF);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h00000000);
    wr(OFF_MASK, 32'h00000000);
    pair(16'h1233, 16'h1234, 0, 0);
    rdchk(OFF_STATUS, 32'hFFFFFFFF, 32'h00004240);
    $display("corrupt telegram done");
  endtask : t_lost

  task automatic t_fsk();
    logic [31:0] c;
    rd(OFF_PASS, c);
    wr(OFF_CTRL, 32'h00000000);
    wr(OFF_STATUS, 32'hFFFFFFFF);
    pair(16'h8233, 16'h8233, 0, 0);
    rdchk(OFF_STATUS, 32'hFFFFFFFF, 32'h00000000);
    rdchk(OFF_WORD, 32'h0000FFFF, 32'h00001233);
    rdchk(OFF_PASS, 32'hFFFFFFFF, c);
    wr(OFF_CTRL, 32'h00000001);
    wr(OFF_STATUS, 32'hFFFFFFFF);
    pair(16'h8233, 16'h8233, 0, 0);
    rdchk(OFF_STATUS, 32'hFFFFFFFF, 32'h0000C0C0);
    rdchk(OFF_WORD, 32'h0000FFFF, 32'h00008233);
    rdchk(OFF_PASS, 32'hFFFFFFFF, c + 32'h00000001);
    $display("type indication done");
  endtask : t_fsk

  task automatic t_mid();
    rest();
    wr(OFF_STATUS, 32'hFFFFFFFF);
    fork
      begin
        u_src0.frame(16'h1233, 16);
        u_src0.lc(32);
        u_src0.frame(16'h1233, 24);
      end
      begin
        u_src1.frame(16'h1233, 16);
        u_src1.lc(32);
        u_src1.frame(16'h1233, 24);
      end
    join
    repeat (8) @(posedge hclk);
    rdchk(OFF_STATUS, 32'hFFFFFFFF, 32'h00004040);
    $display("link check inside passage done");
  endtask : t_mid

  task automatic t_long();
    rest();
    wr(OFF_STATUS, 32'hFFFFFFFF);
    fork
      u_src0.lc(32);
      u_src1.lc(70);
    join
    repeat (8) @(posedge hclk);
    rdchk(OFF_STATUS, 32'h00000808, 32'h00000800);
    $display("long link check done");
  endtask : t_long

  task automatic t_rate(input int p0, input int p1, input logic [31:0] exp);
    rest();
    wr(OFF_STATUS, 32'hFFFFFFFF);
    setp(p0, p1);
    fork
      u_src0.lc(32);
      u_src1.lc(32);
    join
    setp(64, 64);
    repeat (8) @(posedge hclk);
    rdchk(OFF_STATUS, 32'h00000101, exp);
    $display("rate periods %0d %0d done", p0, p1);
  endtask : t_rate

  task automatic t_faults();
    rest();
    wr(OFF_STATUS, 32'hFFFFFFFF);
    fork
      begin
        repeat (10) u_src0.frame(16'h1233, 24);
        u_src0.idle();
      end
      repeat (5) begin
        u_src1.lc(32);
        u_src1.frame(16'h1233, 24);
      end
    join
    rdchk(OFF_STATUS, 32'h00000404, 32'h00000004);
    wr(OFF_STATUS, 32'hFFFFFFFF);
    // channel 0 clock stays still while channel 1 keeps running
    repeat (3) begin
      u_src1.lc(32);
      u_src1.frame(16'h1233, 24);
    end
    check({30'h0, unavail}, 32'h00000001);
    rdchk(OFF_LIVE, 32'h00030003, 32'h00000001);
    rdchk(OFF_STATUS, 32'h00001010, 32'h00000010);
    wr(OFF_STATUS, 32'hFFFFFFFF);
    repeat (5) begin
      u_src0.lc(32);
      u_src0.frame(16'h1233, 24);
    end
    check({30'h0, unavail}, 32'h00000002);
    rdchk(OFF_LIVE, 32'h00030003, 32'h00020002);
    rdchk(OFF_STATUS, 32'h00002020, 32'h00002000);
    pair(16'h1233, 16'h1233, 0, 0);
    check({30'h0, unavail}, 32'h00000000);
    $display("stall and inactive done");
  endtask : t_faults

  // reset, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'b00;
    hsize = 3'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_good(64, 32, 0, 0);
    t_good(58, 29, 0, 0);
    t_good(70, 35, 0, 0);
    t_good(64, 24, 0, 0);
    t_good(64, 40, 0, 0);
    t_good(64, 32, 0, 24);
    t_good(64, 32, 24, 0);
    t_lost();
    t_fsk();
    t_mid();
    t_long();
    t_rate(54, 64, 32'h00000001);
    t_rate(64, 74, 32'h00000100);
    t_faults();
    end_of_test();
  end

  // watchdog against a hung handshake or link
  initial begin
    repeat (100000) @(posedge hclk);
    fail_count++;
    end_of_test();
  end
endmodule : testbench

// ---- sim/tlrm_link_src.sv ----
// link transmitter model: clocked serial bits, frames and link checks
`timescale 1ns/100ps
module tlrm_link_src (
  // link pins
  output logic clk_o,
  output logic data_o
);
  int per_ns = 64;
  int hi_ns = 32;

  // clock stands low between bursts, data starts high
  initial begin
    clk_o = 1'b0;
    data_o = 1'b1;
  end

  // one bit: data changes with the fall, clock rises late in the bit
  task automatic send_bit(input logic b);
    data_o = b;
    #(per_ns - hi_ns);
    clk_o = 1'b1;
    #(hi_ns);
    clk_o = 1'b0;
  endtask : send_bit

  // sync word then body msb first, cut short after n bits if asked
  task automatic frame(input logic [15:0] w, input int n);
    logic [23:0] v;
    v = {8'h5A, w};
    // keep pin edges off the system clock edges
    if (($time % 4) == 0) #1;
    for (int i = 23; i >= 24 - n; i--) begin
      send_bit(v[i]);
    end
  endtask : frame

  // link check: run of ones closed by a zero
  task automatic lc(input int n);
    if (($time % 4) == 0) #1;
    for (int i = 0; i < n; i++) begin
      send_bit(1'b1);
    end
    send_bit(1'b0);
  endtask : lc

  // released data line shows the inverse of its last bit
  task automatic idle();
    data_o = ~data_o;
  endtask : idle
endmodule : tlrm_link_src
